// ===== rtl/uart_pkg.sv
package uart_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_TXD = 8'h08;
  localparam logic [7:0] OFF_RXD = 8'h0C;
  // Control register field positions
  localparam int C_FLOW = 0, C_AB = 2, C_AF = 3, C_BAUD = 4, C_FRM = 8;
  localparam int C_MUX = 11, C_MCH = 12, C_CMD = 15, C_DMODE = 16;
  localparam int C_DSR = 17, C_DTR = 18, C_DCD = 19, C_CAR = 20;
  // Status register field positions
  localparam int S_RXV = 0, S_PERR = 1, S_FERR = 2, S_OVR = 3, S_TXF = 4;
  localparam int S_XOFF = 5, S_DROP = 6, S_ARM = 7, S_BAUD = 8;
  localparam int S_FRM = 12, S_CHK = 15;
  // Baud indices and reset values
  localparam logic [3:0] B_1200 = 4'h0, B_115K = 4'h7, B_230K = 4'h8;
  localparam logic [3:0] B_460K = 4'h9, B_MAX = 4'hA;
  localparam logic [3:0] BAUD_RST = B_115K;
  localparam logic [7:0] CH_XON = 8'h11, CH_XOFF = 8'h13, CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A, CH_O = 8'h4F, CH_K = 8'h4B;
  localparam logic [2:0] MCH_CTRL = 3'h0, MCH_AT_HI = 3'h5;
  localparam logic [2:0] MCH_GNSS = 3'h6, MCH_SIM = 3'h7;
  localparam logic [3:0] DET_SLOTS = 4'h9;
  typedef enum logic [1:0] {FLOW_NONE = 2'h0, FLOW_HW = 2'h1,
                            FLOW_SW = 2'h2} flow_e;
  typedef enum logic [2:0] {F8N1 = 3'h0, F8E1 = 3'h1, F8O1 = 3'h2,
                            F8N2 = 3'h3, F7E1 = 3'h4, F7O1 = 3'h5} frame_e;
  typedef enum logic [2:0] {ST_TRI = 3'h1, ST_DRV = 3'h2,
                            ST_ACT = 3'h4} init_e;
  typedef enum logic [3:0] {RX_IDLE = 4'h1, RX_MEAS = 4'h2, RX_BITS = 4'h4,
                            RX_END = 4'h8} rx_e;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} tx_e;

  function automatic int unsigned rate(input logic [3:0] i);
    case (i)
      4'h0: return 1200;
      4'h1: return 2400;
      4'h2: return 4800;
      4'h3: return 9600;
      4'h4: return 19200;
      4'h5: return 38400;
      4'h6: return 57600;
      4'h8: return 230400;
      4'h9: return 460800;
      4'hA: return 921600;
      default: return 115200;
    endcase
  endfunction

  function automatic logic [17:0] baud_div(input logic [3:0] i,
                                           input int unsigned clk);
    return 18'(clk / rate(i));
  endfunction
endpackage

// ===== rtl/modem_uart_dce_port.sv
// Function
// - Nine-wire V.24 serial port, data plus handshakes
// - Low level means zero bit or ON
// - Terminal drives TXD, modem receives it
// - Flow control hardware, XON/XOFF or none; hardware default
// - Continuous variant re-detects rate per command
// - One-shot variant detects once at start-up
// - Autobaud on by default; else 115200
// - Eleven fixed rates from 1200 to 921600
// - Continuous variant offers no 460800 or 921600
// - Continuous detector skips 1200 and 230400
// - One-shot detector skips 460800 and 921600
// - Frame format detected with rate, default on
// - Six frame formats, 8N1 default
// - Pins tri-stated, then reset levels, then active
// - Command handling enabled after initialisation
// - RXD high at init and when idle
// - DSR ON in data mode, OFF otherwise
// - DTR ON-to-OFF gives online command, OK
// - DCD follows carrier detect
// - Mux off by default; fixed channel roles
// - RTS OFF stops transmission within two characters
// - CTS ON at initialisation
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module modem_uart_dce_port import uart_pkg::*; #(
  parameter int unsigned CLK_HZ_P = CLK_HZ,
  parameter bit ONE_SHOT_P = 1'b0
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TXD,
  output logic RXD,
  input wire logic RTS_N,
  output logic CTS_N,
  input wire logic DTR_N,
  output logic DSR_N,
  output logic DCD_N,
  output logic RI_N,
  output logic PIN_OE,
  output logic CMD_EN,
  output logic MUX_EN
);
  logic [2:0] s1_q, s2_q, s3_q;
  init_e st_q;
  logic act, rx_in, rts_on, dtr_ev, take, wr_ctrl, wr_stat, wr_txd, rd_rxd;
  logic ap_wr_q;
  logic [7:0] aa_q;
  flow_e flow_q;
  logic ab_q, af_q, mux_q, cmd_q, dmode_q, dsr_q, dtrc_q, dcd_q, car_q;
  logic drop_q;
  logic [3:0] baud_q;
  logic [2:0] frame_q, mch_q;
  rx_e rx_q;
  logic [17:0] rx_tmr_q, div;
  logic [3:0] rx_cnt_q, det_idx_q;
  logic [10:0] rx_sh_q;
  logic rx_det_q, arm_q, det_b_q, det_f_q, xoff_q;
  logic [2:0] det_frm_q;
  logic [7:0] rx_data_q;
  logic rx_valid_q, perr_q, ferr_q, ovr_q;
  tx_e tx_q;
  logic [11:0] tx_sh_q;
  logic [3:0] tx_left_q;
  logic [17:0] tx_tmr_q;
  logic [7:0] hold_q;
  logic hold_full_q, line_q, gate;
  logic [2:0] ok_q;

  function automatic logic [3:0] fr_db(input logic [2:0] f);
    return (f == F7E1 || f == F7O1) ? 4'h7 : 4'h8;
  endfunction
  function automatic logic fr_hasp(input logic [2:0] f);
    return f == F8E1 || f == F8O1 || f == F7E1 || f == F7O1;
  endfunction
  function automatic logic fr_odd(input logic [2:0] f);
    return f == F8O1 || f == F7O1;
  endfunction
  function automatic logic [3:0] fr_slots(input logic [2:0] f);
    return 4'(fr_db(f) + {3'h0, fr_hasp(f)} + ((f == F8N2) ? 4'h2 : 4'h1));
  endfunction
  function automatic logic baud_ok(input logic [3:0] i, input logic os);
    return os ? (i <= B_MAX) : (i < B_460K);
  endfunction
  function automatic logic det_ok(input int i, input logic os);
    return os ? (i < 9) : (i > 0 && i < 8);
  endfunction
  function automatic logic [3:0] pick(input logic [17:0] w,
                                      input logic os);
    logic [3:0] r;
    r = os ? 4'h0 : 4'h1;
    for (int i = 0; i < 11; i++) begin
      if (det_ok(i, os) &&
          32'(w) * 4 < 32'(baud_div(4'(i), CLK_HZ_P)) * 5) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction
  function automatic logic [11:0] tx_vec(input logic [2:0] f,
                                         input logic [7:0] d);
    logic [11:0] v;
    logic [7:0] m;
    v = '1;
    m = (fr_db(f) == 4'h7) ? {1'b0, d[6:0]} : d;
    v[0] = 1'b0;
    v[8:1] = m;
    if (fr_hasp(f)) begin
      v[4'(fr_db(f) + 4'h1)] = ^m ^ fr_odd(f);
    end
    return v;
  endfunction
  function automatic logic [1:0] ch_kind(input logic [2:0] c);
    if (c == MCH_CTRL) return 2'h0;
    if (c <= MCH_AT_HI) return 2'h1;
    return (c == MCH_GNSS) ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [7:0] ok_char(input logic [2:0] i);
    case (i)
      3'h1: return CH_O;
      3'h2: return CH_K;
      3'h3: return CH_CR;
      default: return CH_LF;
    endcase
  endfunction

  // Pin synchronisers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
    end else if (CE) begin
      s1_q <= {DTR_N, RTS_N, TXD};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rx_in = s2_q[0];
  assign rts_on = ~s2_q[1];
  assign act = st_q == ST_ACT;
  assign dtr_ev = act && dtrc_q && dmode_q && s2_q[2] && !s3_q[2];

  // Power-up sequencing
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ST_TRI;
    end else if (CE) begin
      case (st_q)
        ST_TRI: st_q <= ST_DRV;
        ST_DRV: st_q <= ST_ACT;
        ST_ACT: st_q <= ST_ACT;
        default: st_q <= ST_TRI;
      endcase
    end
  end

  // Bus address phase
  assign take = HSEL && HTRANS[1] && HREADY;
  assign wr_ctrl = ap_wr_q && aa_q == OFF_CTRL;
  assign wr_stat = ap_wr_q && aa_q == OFF_STAT;
  assign wr_txd = ap_wr_q && aa_q == OFF_TXD;
  assign rd_rxd = take && !HWRITE && HADDR[7:0] == OFF_RXD;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ap_wr_q <= 1'b0;
      aa_q <= 8'h00;
      HRDATA <= 32'h00000000;
    end else if (CE) begin
      ap_wr_q <= take && HWRITE;
      if (take) aa_q <= HADDR[7:0];
      if (take && !HWRITE) begin
        HRDATA <= 32'h00000000;
        case (HADDR[7:0])
          OFF_CTRL: begin
            HRDATA[C_FLOW+:2] <= flow_q;
            HRDATA[C_AB] <= ab_q;
            HRDATA[C_AF] <= af_q;
            HRDATA[C_BAUD+:4] <= baud_q;
            HRDATA[C_FRM+:3] <= frame_q;
            HRDATA[C_MUX] <= mux_q;
            HRDATA[C_MCH+:3] <= mch_q;
            HRDATA[C_CMD] <= cmd_q;
            HRDATA[C_DMODE] <= dmode_q;
            HRDATA[C_DSR] <= dsr_q;
            HRDATA[C_DTR] <= dtrc_q;
            HRDATA[C_DCD] <= dcd_q;
            HRDATA[C_CAR] <= car_q;
          end
          OFF_STAT: begin
            HRDATA[S_RXV] <= rx_valid_q;
            HRDATA[S_PERR] <= perr_q;
            HRDATA[S_FERR] <= ferr_q;
            HRDATA[S_OVR] <= ovr_q;
            HRDATA[S_TXF] <= hold_full_q;
            HRDATA[S_XOFF] <= xoff_q;
            HRDATA[S_DROP] <= drop_q;
            HRDATA[S_ARM] <= arm_q;
            HRDATA[S_BAUD+:4] <= baud_q;
            HRDATA[S_FRM+:3] <= frame_q;
            HRDATA[S_CHK+:2] <= ch_kind(mch_q);
          end
          OFF_RXD: HRDATA[7:0] <= rx_data_q;
          default: HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration and mode
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flow_q <= FLOW_HW;
      ab_q <= 1'b1;
      af_q <= 1'b1;
      baud_q <= BAUD_RST;
      frame_q <= F8N1;
      mux_q <= 1'b0;
      mch_q <= MCH_CTRL;
      cmd_q <= 1'b1;
      dmode_q <= 1'b0;
      dsr_q <= 1'b1;
      dtrc_q <= 1'b1;
      dcd_q <= 1'b1;
      car_q <= 1'b0;
      drop_q <= 1'b0;
    end else if (CE) begin
      if (wr_ctrl) begin
        if (HWDATA[C_FLOW+:2] != 2'h3) flow_q <= flow_e'(HWDATA[C_FLOW+:2]);
        ab_q <= HWDATA[C_AB];
        af_q <= HWDATA[C_AF];
        if (baud_ok(HWDATA[C_BAUD+:4], ONE_SHOT_P)) begin
          baud_q <= HWDATA[C_BAUD+:4];
        end
        if (HWDATA[C_FRM+:3] <= F7O1) frame_q <= HWDATA[C_FRM+:3];
        mux_q <= HWDATA[C_MUX];
        mch_q <= HWDATA[C_MCH+:3];
        cmd_q <= HWDATA[C_CMD];
        dmode_q <= HWDATA[C_DMODE];
        dsr_q <= HWDATA[C_DSR];
        dtrc_q <= HWDATA[C_DTR];
        dcd_q <= HWDATA[C_DCD];
        car_q <= HWDATA[C_CAR];
      end
      if (det_b_q && ab_q) baud_q <= det_idx_q;
      if (det_f_q && af_q) frame_q <= det_frm_q;
      if (wr_stat && HWDATA[S_DROP]) drop_q <= 1'b0;
      if (dtr_ev) begin
        dmode_q <= 1'b0;
        drop_q <= 1'b1;
      end
    end
  end

  // Receiver with rate and frame detection
  assign div = baud_div(baud_q, CLK_HZ_P);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_q <= RX_IDLE;
      rx_tmr_q <= 18'h00000;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 11'h7FF;
      rx_det_q <= 1'b0;
      arm_q <= 1'b1;
      det_b_q <= 1'b0;
      det_f_q <= 1'b0;
      det_idx_q <= BAUD_RST;
      det_frm_q <= F8N1;
      xoff_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (CE) begin
      det_b_q <= 1'b0;
      det_f_q <= 1'b0;
      if (rd_rxd) begin
        rx_valid_q <= 1'b0;
        perr_q <= 1'b0;
        ferr_q <= 1'b0;
      end
      if (wr_stat && HWDATA[S_OVR]) ovr_q <= 1'b0;
      if (flow_q != FLOW_SW) xoff_q <= 1'b0;
      case (rx_q)
        RX_IDLE: begin
          rx_cnt_q <= 4'h0;
          rx_sh_q <= 11'h7FF;
          if (act && !rx_in) begin
            if (arm_q && ab_q) begin
              rx_q <= RX_MEAS;
              rx_tmr_q <= 18'h00001;
            end else begin
              rx_q <= RX_BITS;
              rx_det_q <= 1'b0;
              rx_tmr_q <= div >> 1;
            end
          end
        end
        RX_MEAS: begin
          rx_tmr_q <= rx_tmr_q + 18'h00001;
          if (&rx_tmr_q) begin
            rx_q <= RX_IDLE;
          end else if (rx_in) begin
            det_idx_q <= pick(rx_tmr_q, ONE_SHOT_P);
            det_b_q <= 1'b1;
            arm_q <= 1'b0;
            rx_det_q <= 1'b1;
            rx_cnt_q <= 4'h1;
            rx_tmr_q <= baud_div(pick(rx_tmr_q, ONE_SHOT_P), CLK_HZ_P) >> 2;
            rx_q <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_tmr_q != 18'h00000) begin
            rx_tmr_q <= rx_tmr_q - 18'h00001;
          end else begin
            rx_tmr_q <= div - 18'h00001;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'h0) begin
              if (rx_in) rx_q <= RX_IDLE;
            end else begin
              rx_sh_q[rx_cnt_q - 4'h1] <= rx_in;
              if (rx_cnt_q == (rx_det_q ? DET_SLOTS : fr_slots(frame_q))) begin
                rx_q <= RX_END;
              end
            end
          end
        end
        RX_END: begin
          rx_q <= RX_IDLE;
          if (rx_det_q) begin
            det_f_q <= 1'b1;
            det_frm_q <= rx_sh_q[7] ? F7O1 : (!rx_sh_q[8] ? F8E1 : F8N1);
          end else if (flow_q == FLOW_SW &&
                       (rx_sh_q[7:0] == CH_XON || rx_sh_q[7:0] == CH_XOFF)) begin
            xoff_q <= rx_sh_q[7:0] == CH_XOFF;
          end else begin
            rx_data_q <= (fr_db(frame_q) == 4'h7) ? {1'b0, rx_sh_q[6:0]}
                                                  : rx_sh_q[7:0];
            rx_valid_q <= 1'b1;
            if (rx_valid_q && !rd_rxd) ovr_q <= 1'b1;
            perr_q <= fr_hasp(frame_q) &&
                      ((^rx_sh_q[6:0] ^ rx_sh_q[7] ^
                        (fr_db(frame_q) == 4'h8 ? rx_sh_q[8] : 1'b0)) !=
                       fr_odd(frame_q));
            ferr_q <= !rx_sh_q[4'(fr_db(frame_q) + fr_hasp(frame_q))] ||
                      (frame_q == F8N2 && !rx_sh_q[9]);
            if (!ONE_SHOT_P && ab_q && !dmode_q && rx_sh_q[7:0] == CH_CR) begin
              arm_q <= 1'b1;
            end
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // Transmitter towards the terminal
  assign gate = act && !(flow_q == FLOW_HW && !rts_on) &&
                !(flow_q == FLOW_SW && xoff_q);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_q <= TX_IDLE;
      tx_sh_q <= 12'hFFF;
      tx_left_q <= 4'h0;
      tx_tmr_q <= 18'h00000;
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
      line_q <= 1'b1;
      ok_q <= 3'h0;
    end else if (CE) begin
      if (wr_txd && !hold_full_q) begin
        hold_q <= HWDATA[7:0];
        hold_full_q <= 1'b1;
      end
      if (dtr_ev) ok_q <= 3'h1;
      case (tx_q)
        TX_IDLE: begin
          line_q <= 1'b1;
          if (gate && (ok_q != 3'h0 || hold_full_q)) begin
            tx_q <= TX_SEND;
            tx_sh_q <= tx_vec(frame_q, ok_q != 3'h0 ? ok_char(ok_q)
                                                  : hold_q) >> 1;
            line_q <= 1'b0;
            tx_left_q <= fr_slots(frame_q);
            tx_tmr_q <= div - 18'h00001;
            if (ok_q != 3'h0) begin
              ok_q <= (ok_q == 3'h4) ? 3'h0 : ok_q + 3'h1;
            end else begin
              hold_full_q <= 1'b0;
            end
          end
        end
        TX_SEND: begin
          if (tx_tmr_q != 18'h00000) begin
            tx_tmr_q <= tx_tmr_q - 18'h00001;
          end else if (tx_left_q == 4'h0) begin
            tx_q <= TX_IDLE;
            line_q <= 1'b1;
          end else begin
            line_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            tx_left_q <= tx_left_q - 4'h1;
            tx_tmr_q <= div - 18'h00001;
          end
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  // Handshake outputs
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      CTS_N <= 1'b0;
      DSR_N <= 1'b1;
      DCD_N <= 1'b1;
      PIN_OE <= 1'b0;
    end else if (CE) begin
      PIN_OE <= st_q != ST_TRI;
      if (act) begin
        CTS_N <= flow_q == FLOW_HW && rx_valid_q;
        DSR_N <= dsr_q ? !dmode_q : 1'b0;
        DCD_N <= dcd_q ? !car_q : 1'b0;
      end
    end
  end
  assign RXD = line_q;
  assign RI_N = 1'b1;
  assign CMD_EN = cmd_q && act;
  assign MUX_EN = mux_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  property p_rxd_idle;
    tx_q == TX_IDLE && !(CE && gate) |=> RXD;
  endproperty
  a_rxd_idle: assert property (p_rxd_idle) else $error("RXD low idle");
  property p_cts;
    CE && act && flow_q == FLOW_HW |=> CTS_N == $past(rx_valid_q);
  endproperty
  a_cts: assert property (p_cts) else $error("CTS wrong");
  property p_dsr;
    CE && act && dsr_q |=> DSR_N == !$past(dmode_q);
  endproperty
  a_dsr: assert property (p_dsr) else $error("DSR wrong");
  property p_dcd;
    CE && act && dcd_q |=> DCD_N == !$past(car_q);
  endproperty
  a_dcd: assert property (p_dcd) else $error("DCD wrong");
  property p_rts_stop;
    flow_q == FLOW_HW && !rts_on && tx_q == TX_IDLE |=> tx_q == TX_IDLE;
  endproperty
  a_rts_stop: assert property (p_rts_stop) else $error("TX ran");
  property p_dtr;
    CE && dtr_ev |=> !dmode_q && ok_q == 3'h1 && drop_q;
  endproperty
  a_dtr: assert property (p_dtr) else $error("DTR drop missed");
  property p_tri;
    st_q == ST_TRI |-> !PIN_OE;
  endproperty
  a_tri: assert property (p_tri) else $error("Pins driven early");
  property p_baud;
    ONE_SHOT_P || baud_q < B_460K;
  endproperty
  a_baud: assert property (p_baud) else $error("Rate not offered");
  property p_frame;
    frame_q <= F7O1;
  endproperty
  a_frame: assert property (p_frame) else $error("Bad frame");
  c_det: cover property (det_b_q ##[1:1000] det_f_q);
  c_rx: cover property (rx_q == RX_END ##1 rx_valid_q);
  c_dtr: cover property (dtr_ev ##1 tx_q == TX_SEND);
endmodule // modem_uart_dce_port
`default_nettype wire

// ===== tb/dte_model.sv
`timescale 1ns/1ps
`default_nettype none
module dte_model (
  input wire logic clk,
  input wire logic rxd,
  output logic txd,
  output logic got,
  output logic [7:0] got_byte
);
  int bt = 17;
  logic [7:0] sh;
  initial begin
    txd = 1'b1; // Terminal drives data line, idle high
    got = 1'b0;
    got_byte = 8'h00;
  end
  // Send one char; par < 0 means no parity bit
  task automatic send(input logic [7:0] b, input int par);
    txd <= 1'b0; // Low start bit
    repeat (bt) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      txd <= b[i]; // LSB first
      repeat (bt) @(posedge clk);
    end
    if (par >= 0) begin
      txd <= par[0];
      repeat (bt) @(posedge clk);
    end
    txd <= 1'b1; // High stop bit
    repeat (bt) @(posedge clk);
  endtask
  // Receive 8N1 chars, sampled mid-bit
  always begin
    @(negedge rxd);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk);
      sh[i] = rxd; // LSB first
    end
    repeat (bt) @(posedge clk);
    got_byte <= rxd ? sh : ~sh; // Bad stop corrupts the byte
    got <= 1'b1;
    @(posedge clk);
    got <= 1'b0;
  end
endmodule // dte_model
`default_nettype wire

// ===== tb/modem_uart_dce_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module modem_uart_dce_port_bench;
  import uart_pkg::*;
  localparam logic [31:0] C0 = 32'h000E8071;
  logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, rxd, txd, rts_n = 1'b0, cts_n, dtr_n = 1'b0;
  logic dsr_n, dcd_n, ri_n, pin_oe, cmd_en, mux_en, got;
  logic [7:0] got_byte, b;
  logic [7:0] exp_q[$];
  int err_count = 0, check_count = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  modem_uart_dce_port #(.CLK_HZ_P(2_000_000)) dut (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TXD(txd),
    .RXD(rxd), .RTS_N(rts_n), .CTS_N(cts_n), .DTR_N(dtr_n), .DSR_N(dsr_n),
    .DCD_N(dcd_n), .RI_N(ri_n), .PIN_OE(pin_oe), .CMD_EN(cmd_en),
    .MUX_EN(mux_en));
  dte_model dte (.clk(clk_sys), .rxd(rxd), .txd(txd), .got(got),
    .got_byte(got_byte));
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h0, rv);
  endtask
  task automatic drain;
    while (exp_q.size() > 0) @(posedge clk_sys);
  endtask
  // Monitor: each char seen at the terminal against oldest note
  always @(posedge clk_sys) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk({24'h0, got_byte}, 32'hFFFFFFFF);
      end else begin
        chk({24'h0, got_byte}, {24'h0, exp_q.pop_front()});
      end
    end
  end
  initial begin
    #200_000;
    err_count++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h28a61649));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({28'h0, rxd, cts_n, pin_oe, ri_n}, 32'hB);
    @(posedge clk_sys);
    rd(OFF_CTRL);
    chk(rv, 32'h000E807D);
    chk({30'h0, cmd_en, mux_en}, 32'h2);
    wr(OFF_CTRL, 32'h000E813D);
    dte.send(8'h41, -1);
    repeat (3) @(posedge clk_sys);
    rd(OFF_STAT);
    chk(rv & 32'h00007F81, 32'h00000700);
    dte.send(CH_CR, -1);
    repeat (3) @(posedge clk_sys);
    rd(OFF_RXD);
    chk(rv, {24'h0, CH_CR});
    rd(OFF_STAT);
    chk({31'h0, rv[S_ARM]}, 32'h1);
    wr(OFF_CTRL, (C0 & ~32'hF0) | 32'h90);
    rd(OFF_STAT);
    chk({28'h0, rv[11:8]}, {28'h0, B_115K});
    wr(OFF_CTRL, (C0 & ~32'hF0) | 32'h30);
    rd(OFF_STAT);
    chk({28'h0, rv[11:8]}, 32'h3);
    wr(OFF_CTRL, C0);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      do rd(OFF_STAT); while (rv[S_TXF] !== 1'b0);
      wr(OFF_TXD, {24'h0, b});
    end
    drain();
    b = 8'($urandom);
    dte.send(b, -1);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, cts_n}, 32'h1);
    rd(OFF_RXD);
    chk(rv, {24'h0, b});
    rd(OFF_STAT);
    chk({31'h0, rv[S_RXV]}, 32'h0);
    wr(OFF_CTRL, C0 | 32'h100);
    dte.send(b, int'(~^b));
    repeat (3) @(posedge clk_sys);
    rd(OFF_STAT);
    chk({31'h0, rv[S_PERR]}, 32'h1);
    rd(OFF_RXD);
    rd(OFF_STAT);
    chk({31'h0, rv[S_PERR]}, 32'h0);
    wr(OFF_CTRL, C0);
    rts_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    b = 8'($urandom);
    wr(OFF_TXD, {24'h0, b});
    repeat (200) @(posedge clk_sys);
    exp_q.push_back(b);
    rts_n <= 1'b0;
    drain();
    wr(OFF_CTRL, C0 ^ 32'h3);
    dte.send(CH_XOFF, -1);
    repeat (3) @(posedge clk_sys);
    rd(OFF_STAT);
    chk({31'h0, rv[S_XOFF]}, 32'h1);
    wr(OFF_TXD, {24'h0, b});
    repeat (200) @(posedge clk_sys);
    exp_q.push_back(b);
    dte.send(CH_XON, -1);
    drain();
    wr(OFF_CTRL, C0 | 32'h00110000);
    repeat (3) @(posedge clk_sys);
    chk({30'h0, dsr_n, dcd_n}, 32'h0);
    exp_q.push_back(CH_O);
    exp_q.push_back(CH_K);
    exp_q.push_back(CH_CR);
    exp_q.push_back(CH_LF);
    dtr_n <= 1'b1;
    drain();
    rd(OFF_CTRL);
    chk({31'h0, rv[C_DMODE]}, 32'h0);
    chk({31'h0, dsr_n}, 32'h1);
    wr(OFF_CTRL, C0 | 32'h6800);
    rd(OFF_STAT);
    chk({30'h0, rv[S_CHK+:2]}, 32'h2);
    chk({31'h0, mux_en}, 32'h1);
    stop_test;
  end
endmodule // modem_uart_dce_port_bench
`default_nettype wire
